// ==== sfpi_device_end.sv ====
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RQ1] quad enable turns pause pin into lane 3
// [RQ2] separate reset part: shared pin always pauses
// [RQ3] pause freezes the sequence, state kept
// [RQ4] paused and selected: serial output released
// [RQ5] pause released: sequence carries on
// [RQ6] reset low: held in reset, outputs released
// [RQ7] master avoids reset during internal writes
// [RQ8] dedicated reset pin pulled up internally
// [RQ9] select bit: zero pause, one reset
// [RQ10] dual mode: lanes 0 and 1 bidirectional
// [RQ11] quad mode: lanes 0 to 3 bidirectional
// [RQ12] only modes 0 and 3, idle level
// [RQ13] inputs sampled on rising clock edge
// [RQ14] outputs driven from falling clock edge
// [RQ15] 4K sectors, blocks of eight or sixteen
// [RQ16] deselected: outputs released, no data taken
// [RQ17] select must go high then low first
// [RQ18] master changes pause only while clock low
module sfpi_device_end
  import sfpi_pkg::*;
(
  input  wire logic                         sys_clk,
  input  wire logic                         reset,
  sfpi_link_if.dev                          link,
  input  wire logic                         quadLaneEnable,
  input  wire logic                         pinFunctionSelect,
  input  wire logic                         dedicatedResetPart,
  input  wire logic                         fourLaneCommandMode,
  input  wire logic [1:0]                   laneMode,
  input  wire logic                         txEnable,
  input  wire logic [7:0]                   txByte,
  output logic      [7:0]                   rxByte,
  output logic                              rxValid,
  output logic                              frameActive,
  output logic                              pausedNow,
  output logic                              inReset,
  output logic                              spiMode3,
  input  wire logic [ADDR_WIDTH-1:0]        arrayAddr,
  output logic      [SECTOR_IDX_WIDTH-1:0]  sectorIdx,
  output logic      [BLOCK32_IDX_WIDTH-1:0] block32Idx,
  output logic      [BLOCK64_IDX_WIDTH-1:0] block64Idx
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [SYNC_WIDTH-1:0] pinRaw;
  logic [SYNC_WIDTH-1:0] syncA_reg;
  logic [SYNC_WIDTH-1:0] syncB_reg;

  // raw pin vector
  assign pinRaw = {link.lane, link.resetN, link.selectN, link.sck};

  // two flip-flops per pin
  genvar gi;
  for (gi = 0; gi < SYNC_WIDTH; gi++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        syncA_reg[gi] <= 1'b1;
        syncB_reg[gi] <= 1'b1;
      end else begin
        syncA_reg[gi] <= pinRaw[gi];
        syncB_reg[gi] <= syncA_reg[gi];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded pin levels and edges
  logic       sckS;
  logic       selNS;
  logic       rstNS;
  logic [3:0] laneS;
  logic       sckPrev_reg;
  logic       selNPrev_reg;
  logic       sckRise;
  logic       sckFall;
  logic       selFall;

  // synchronised levels
  assign sckS  = syncB_reg[SYNC_SCK];
  assign selNS = syncB_reg[SYNC_SELN];
  assign rstNS = syncB_reg[SYNC_RSTN];
  assign laneS = syncB_reg[SYNC_LANE0+3:SYNC_LANE0];

  // edge history
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sckPrev_reg  <= 1'b1; // matches synchroniser preset, no false edge
      selNPrev_reg <= 1'b1;
    end else begin
      sckPrev_reg  <= sckS;
      selNPrev_reg <= selNS;
    end
  end

  // edge strobes
  assign sckRise = sckS & ~sckPrev_reg;
  assign sckFall = ~sckS & sckPrev_reg;
  assign selFall = ~selNS & selNPrev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // shared pin role and lane mode
  logic       lane3IsData;
  logic       pinIsPause;
  logic       pinIsReset;
  logic       pauseActive;
  logic       hwResetActive;
  logic       selected;
  logic [1:0] modeEff;

  // shared pin is pause or reset only while it is not a data lane
  assign lane3IsData   = quadLaneEnable | fourLaneCommandMode; // RQ1 RQ11
  assign pinIsPause    = ~lane3IsData & (dedicatedResetPart | ~pinFunctionSelect); // RQ1 RQ2 RQ9
  assign pinIsReset    = ~lane3IsData & ~dedicatedResetPart & pinFunctionSelect; // RQ9
  assign selected      = ~selNS;
  assign pauseActive   = pinIsPause & ~laneS[3] & selected; // RQ3
  // reset from dedicated pin or shared pin
  assign hwResetActive = dedicatedResetPart ? ~rstNS : (pinIsReset & ~laneS[3]); // RQ6
  // quad lanes need the quad enable or four-lane command mode, else fall back to one lane
  assign modeEff = fourLaneCommandMode ? LANES_QUAD :
                   (laneMode == LANES_QUAD && !quadLaneEnable) ? LANES_SINGLE :
                   (laneMode == LANES_QUAD || laneMode == LANES_DUAL) ? laneMode :
                   LANES_SINGLE; // RQ1 RQ10 RQ11

  ////////////////////////////////////////////////////////////////////////////
  // serial engine
  logic       armed_reg;
  logic [2:0] groupIdx_reg;
  logic [7:0] rxShift_reg;
  logic [7:0] rxByte_reg;
  logic       rxValid_reg;
  logic [3:0] outBits_reg;
  logic       spiMode3_reg;
  logic       running;
  logic [7:0] rxMerged;
  logic       lastGroup;

  // frame may shift only when selected, armed and not paused
  assign running   = selected & armed_reg & ~pauseActive; // RQ3 RQ5 RQ16 RQ17
  assign rxMerged  = sfpi_merge(rxShift_reg, modeEff, laneS);
  assign lastGroup = (groupIdx_reg == sfpi_last_group(modeEff));

  // arming, capture on rising edge, drive on falling edge
  always_ff @(posedge sys_clk) begin
    rxValid_reg <= 1'b0;
    if (reset || hwResetActive) begin // RQ6
      armed_reg    <= 1'b0;
      groupIdx_reg <= GROUP_RESET;
      rxShift_reg  <= BYTE_RESET;
      rxByte_reg   <= BYTE_RESET;
      outBits_reg  <= LANE_RESET;
      spiMode3_reg <= 1'b0;
    end else if (selNS) begin
      armed_reg    <= 1'b1; // RQ17
      groupIdx_reg <= GROUP_RESET; // RQ16
    end else if (selFall && armed_reg) begin
      spiMode3_reg <= sckS; // RQ12
      outBits_reg  <= sfpi_slice(txByte, modeEff, GROUP_RESET);
    end else if (running && sckRise) begin // RQ13
      rxShift_reg <= rxMerged;
      if (lastGroup) begin
        rxByte_reg   <= rxMerged;
        rxValid_reg  <= 1'b1;
        groupIdx_reg <= GROUP_RESET;
      end else begin
        groupIdx_reg <= groupIdx_reg + 3'h1;
      end
    end else if (running && sckFall) begin
      outBits_reg <= sfpi_slice(txByte, modeEff, groupIdx_reg); // RQ14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lane drivers
  logic       driveOk;
  logic [3:0] laneOeMode;
  logic [3:0] laneOutMode;

  // no drive in reset, deselected, paused or unarmed
  assign driveOk = running & txEnable & ~hwResetActive; // RQ4 RQ6 RQ16

  // one lane uses output pin only, more lanes are bidirectional
  assign laneOeMode  = (modeEff == LANES_QUAD) ? 4'hf :
                       (modeEff == LANES_DUAL) ? 4'h3 : 4'h2; // RQ10 RQ11
  assign laneOutMode = (modeEff == LANES_QUAD) ? outBits_reg :
                       (modeEff == LANES_DUAL) ? {2'b00, outBits_reg[1:0]} :
                       {2'b00, outBits_reg[0], 1'b0};

  // pin drive
  assign link.devLaneOe  = driveOk ? laneOeMode : 4'h0; // RQ4
  assign link.devLaneOut = laneOutMode;

  ////////////////////////////////////////////////////////////////////////////
  // array address decode
  logic [SECTOR_IDX_WIDTH-1:0]  sectorIdx_reg;
  logic [BLOCK32_IDX_WIDTH-1:0] block32Idx_reg;
  logic [BLOCK64_IDX_WIDTH-1:0] block64Idx_reg;

  // sector and block numbers of an address
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sectorIdx_reg  <= '0;
      block32Idx_reg <= '0;
      block64Idx_reg <= '0;
    end else begin
      sectorIdx_reg  <= arrayAddr[ADDR_WIDTH-1:SECTOR_SHIFT]; // RQ15
      block32Idx_reg <= arrayAddr[ADDR_WIDTH-1:BLOCK32_SHIFT]; // RQ15
      block64Idx_reg <= arrayAddr[ADDR_WIDTH-1:BLOCK64_SHIFT]; // RQ15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // user side outputs
  assign rxByte      = rxByte_reg;
  assign rxValid     = rxValid_reg;
  assign frameActive = selected & armed_reg;
  assign pausedNow   = pauseActive;
  assign inReset     = hwResetActive;
  assign spiMode3    = spiMode3_reg;
  assign sectorIdx   = sectorIdx_reg;
  assign block32Idx  = block32Idx_reg;
  assign block64Idx  = block64Idx_reg;

endmodule
`default_nettype wire

// ==== sfpi_host_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfpi_host_end
  import sfpi_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  sfpi_link_if.host       link,
  input  wire logic       start,
  input  wire logic       cpolHigh,
  input  wire logic [1:0] laneMode,
  input  wire logic       writeDir,
  input  wire logic [7:0] txByte,
  input  wire logic       pauseReq,
  input  wire logic       resetReq,
  input  wire logic       pinRoleReset,
  input  wire logic       dedicatedResetPart,
  output logic            busy,
  output logic            done,
  output logic      [7:0] rxByte
);

  ////////////////////////////////////////////////////////////////////////////
  // lane synchroniser
  logic [3:0] laneA_reg;
  logic [3:0] laneB_reg;

  // two flip-flops on returning lanes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      laneA_reg <= 4'hf;
      laneB_reg <= 4'hf;
    end else begin
      laneA_reg <= link.lane;
      laneB_reg <= laneA_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  sfpi_host_state_e state_reg;
  logic [3:0]       halfCnt_reg;
  logic [2:0]       groupIdx_reg;
  logic [1:0]       mode_reg;
  logic             dir_reg;
  logic             cpol_reg;
  logic [7:0]       txByte_reg;
  logic [7:0]       rxShift_reg;
  logic [7:0]       rxByte_reg;
  logic [3:0]       dataOut_reg;
  logic             sck_reg;
  logic             selN_reg;
  logic             pause_reg;
  logic             reset_reg;
  logic             done_reg;
  logic             halfTick;
  logic             holdClock;
  logic [3:0]       capture;
  logic [7:0]       rxMerged;

  // half period timing, stalled while paused
  assign holdClock = (state_reg == HOST_LOW) && pause_reg; // RQ3 RQ5
  assign halfTick  = (halfCnt_reg == SCK_HALF_CYC - 4'h1) && !holdClock;
  // single lane reads the output pin
  assign capture   = (mode_reg == LANES_SINGLE) ? {3'b000, laneB_reg[1]} : laneB_reg;
  assign rxMerged  = sfpi_merge(rxShift_reg, mode_reg, capture);

  // half period counter
  always_ff @(posedge sys_clk) begin
    if (reset || state_reg == HOST_IDLE || halfTick) begin
      halfCnt_reg <= 4'h0;
    end else if (!holdClock) begin
      halfCnt_reg <= halfCnt_reg + 4'h1;
    end
  end

  // pause and reset request capture
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pause_reg <= 1'b0;
      reset_reg <= 1'b0;
    end else begin
      if (!sck_reg) begin
        pause_reg <= pauseReq; // RQ18
      end
      if (state_reg == HOST_IDLE) begin
        reset_reg <= resetReq; // RQ7
      end
    end
  end

  // transfer state machine
  always_ff @(posedge sys_clk) begin
    done_reg <= 1'b0;
    if (reset) begin
      state_reg    <= HOST_IDLE;
      groupIdx_reg <= GROUP_RESET;
      mode_reg     <= LANES_SINGLE;
      dir_reg      <= 1'b0;
      cpol_reg     <= 1'b0;
      txByte_reg   <= BYTE_RESET;
      rxShift_reg  <= BYTE_RESET;
      rxByte_reg   <= BYTE_RESET;
      dataOut_reg  <= LANE_RESET;
      sck_reg      <= 1'b0;
      selN_reg     <= 1'b1;
    end else begin
      case (state_reg)
        HOST_IDLE: begin
          sck_reg  <= cpolHigh; // RQ12
          cpol_reg <= cpolHigh;
          selN_reg <= 1'b1;
          if (start && !reset_reg) begin
            state_reg    <= HOST_LEAD;
            selN_reg     <= 1'b0; // RQ17
            groupIdx_reg <= GROUP_RESET;
            mode_reg     <= laneMode;
            dir_reg      <= writeDir;
            txByte_reg   <= txByte;
            dataOut_reg  <= sfpi_slice(txByte, laneMode, GROUP_RESET);
          end
        end
        HOST_LEAD: begin
          if (halfTick) begin
            state_reg <= HOST_LOW;
            sck_reg   <= 1'b0;
          end
        end
        HOST_LOW: begin
          if (halfTick) begin
            state_reg <= HOST_HIGH;
            sck_reg   <= 1'b1;
          end
        end
        HOST_HIGH: begin
          if (halfTick) begin
            rxShift_reg <= rxMerged;
            if (groupIdx_reg == sfpi_last_group(mode_reg)) begin
              state_reg  <= HOST_TAIL;
              sck_reg    <= cpol_reg; // RQ12
              rxByte_reg <= rxMerged;
              done_reg   <= 1'b1;
            end else begin
              state_reg    <= HOST_LOW;
              sck_reg      <= 1'b0;
              groupIdx_reg <= groupIdx_reg + 3'h1;
              dataOut_reg  <= sfpi_slice(txByte_reg, mode_reg, groupIdx_reg + 3'h1);
            end
          end
        end
        HOST_TAIL: begin
          if (halfTick) begin
            state_reg <= HOST_IDLE;
            selN_reg  <= 1'b1;
          end
        end
        default: begin
          state_reg <= HOST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lane drivers
  logic       quadMode;
  logic       active;
  logic [3:0] dataOe;
  logic [3:0] dataOut;
  logic [3:0] ctrlOe;
  logic [3:0] ctrlOut;
  logic       lane3Level;

  assign quadMode   = (mode_reg == LANES_QUAD);
  assign active     = (state_reg != HOST_IDLE);
  // data lanes as write source, single lane always drives input pin
  assign dataOe     = !active ? 4'h0 :
                      (mode_reg == LANES_SINGLE) ? 4'h1 :
                      !dir_reg ? 4'h0 :
                      quadMode ? 4'hf : 4'h3; // RQ10 RQ11
  assign dataOut    = dataOut_reg;
  // lane 2 and 3 carry protect and pause or reset outside quad
  assign lane3Level = pinRoleReset ? ~reset_reg : ~pause_reg; // RQ3 RQ9
  assign ctrlOe     = quadMode ? 4'h0 : 4'hc; // RQ1
  assign ctrlOut    = {lane3Level, 1'b1, 2'b00};

  // pin outputs
  assign link.hostLaneOe   = dataOe | ctrlOe;
  assign link.hostLaneOut  = (dataOe & dataOut) | (~dataOe & ctrlOut);
  assign link.hostResetNOut = ~reset_reg; // RQ6
  assign link.hostResetNOe  = dedicatedResetPart;
  assign link.sck          = sck_reg;
  assign link.selectN      = selN_reg;

  // user side
  assign busy   = active;
  assign done   = done_reg;
  assign rxByte = rxByte_reg;

endmodule
`default_nettype wire

// ==== sfpi_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sfpi_link_if;
  logic       sck;
  logic       selectN;
  logic       hostResetNOut;
  logic       hostResetNOe;
  logic [3:0] hostLaneOut;
  logic [3:0] hostLaneOe;
  logic [3:0] devLaneOut;
  logic [3:0] devLaneOe;
  wire  [3:0] lane;
  wire        resetN;

  // wire resolution, undriven lanes float high
  genvar i;
  for (i = 0; i < 4; i++) begin : g_lane
    assign lane[i] = hostLaneOe[i] ? hostLaneOut[i] :
                     devLaneOe[i]  ? devLaneOut[i]  : 1'b1;
  end
  // internal pull-up on the dedicated reset pin
  assign resetN = hostResetNOe ? hostResetNOut : 1'b1; // RQ8

  modport dev (
    input  sck,
    input  selectN,
    input  resetN,
    input  lane,
    output devLaneOut,
    output devLaneOe
  );

  modport host (
    output sck,
    output selectN,
    output hostResetNOut,
    output hostResetNOe,
    output hostLaneOut,
    output hostLaneOe,
    input  lane
  );
endinterface
`default_nettype wire

// ==== sfpi_link_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfpi_link_sva (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       sck,
  input wire logic       selectN,
  input wire logic       hostResetNOut,
  input wire logic       hostResetNOe,
  input wire logic [3:0] hostLaneOut,
  input wire logic [3:0] hostLaneOe,
  input wire logic [3:0] devLaneOut,
  input wire logic [3:0] devLaneOe,
  input wire logic [3:0] lane,
  input wire logic       resetN
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic idleSck_reg;
  logic pauseSeen;

  ////////////////////////////////////////////////////////////////////////////
  // idle clock level while deselected, pause condition driven by the host
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      idleSck_reg <= 1'b0;
    end else if (selectN) begin
      idleSck_reg <= sck;
    end
  end
  assign pauseSeen = !selectN && hostLaneOe[3] && !hostLaneOut[3] && !hostLaneOe[1];

  ////////////////////////////////////////////////////////////////////////////
  // link rules
  desel_release_a:
    assert property (selectN [*6] |-> devLaneOe == 4'h0)
    else $error("device drives lanes while deselected");
  hwreset_release_a:
    assert property (!resetN [*6] |-> devLaneOe == 4'h0)
    else $error("device drives lanes while in hardware reset");
  reset_pullup_a:
    assert property (!hostResetNOe |-> resetN)
    else $error("undriven reset pin not high");
  idle_level_a:
    assert property ($rose(selectN) |-> sck == idleSck_reg)
    else $error("clock idle level differs across frame");
  out_steady_a:
    assert property ($rose(sck) && !selectN |-> ##2 $stable(devLaneOut) [*2])
    else $error("device output changed in clock high half");
  no_clash_a:
    assert property ((hostLaneOe & devLaneOe) == 4'h0)
    else $error("both ends drive one lane");
  pause_release_a:
    assert property (pauseSeen [*6] |-> devLaneOe == 4'h0)
    else $error("device drives lanes while paused");
  reset_idle_a:
    assert property ($changed(hostResetNOut) |-> selectN)
    else $error("reset request changed inside a frame");

  // main scenarios
  frame_c: cover property ($fell(selectN));
  mode3_c: cover property ($fell(selectN) && sck);
  pause_c: cover property (pauseSeen [*6]);
  hwrst_c: cover property (!resetN [*6]);
endmodule
`default_nettype wire

// ==== sfpi_pkg.sv ====
`default_nettype none
package sfpi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and serial clock timing
  localparam int         SYS_CLK_PERIOD_NS = 25;
  localparam int         SCK_PERIOD_NS     = 200;
  localparam int         SCK_HALF_NS       = SCK_PERIOD_NS / 2;
  localparam int         SCK_HALF_CYC_INT  = (SCK_HALF_NS + SYS_CLK_PERIOD_NS - 1) /
                                             SYS_CLK_PERIOD_NS;
  localparam logic [3:0] SCK_HALF_CYC      = 4'(SCK_HALF_CYC_INT);

  ////////////////////////////////////////////////////////////////////////////
  // lane modes
  localparam logic [1:0] LANES_SINGLE = 2'h0;
  localparam logic [1:0] LANES_DUAL   = 2'h1;
  localparam logic [1:0] LANES_QUAD   = 2'h2;

  // synchroniser bit positions in the device
  localparam int SYNC_WIDTH = 7;
  localparam int SYNC_SCK   = 0;
  localparam int SYNC_SELN  = 1;
  localparam int SYNC_RSTN  = 2;
  localparam int SYNC_LANE0 = 3;

  ////////////////////////////////////////////////////////////////////////////
  // array organisation
  localparam int ADDR_WIDTH        = 21;
  localparam int SECTOR_SHIFT      = 12;
  localparam int SECTORS_PER_B32   = 8;
  localparam int SECTORS_PER_B64   = 16;
  localparam int BLOCK32_SHIFT     = SECTOR_SHIFT + $clog2(SECTORS_PER_B32);
  localparam int BLOCK64_SHIFT     = SECTOR_SHIFT + $clog2(SECTORS_PER_B64);
  localparam int SECTOR_IDX_WIDTH  = ADDR_WIDTH - SECTOR_SHIFT;
  localparam int BLOCK32_IDX_WIDTH = ADDR_WIDTH - BLOCK32_SHIFT;
  localparam int BLOCK64_IDX_WIDTH = ADDR_WIDTH - BLOCK64_SHIFT;

  // reset values
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  localparam logic [2:0] GROUP_RESET = 3'h0;
  localparam logic [3:0] LANE_RESET  = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // master sequencer states
  typedef enum logic [2:0] {
    HOST_IDLE = 3'b000,
    HOST_LEAD = 3'b001,
    HOST_LOW  = 3'b010,
    HOST_HIGH = 3'b011,
    HOST_TAIL = 3'b100
  } sfpi_host_state_e;

  // bits of group g of a byte, msb first, right-justified
  function automatic logic [3:0] sfpi_slice(input logic [7:0] b,
                                            input logic [1:0] mode,
                                            input logic [2:0] g);
    logic [7:0] s;
    s = 8'h00;
    case (mode)
      LANES_DUAL: begin
        s = b << {g[1:0], 1'b0};
        sfpi_slice = {2'b00, s[7:6]};
      end
      LANES_QUAD: begin
        s = b << {g[0], 2'b00};
        sfpi_slice = s[7:4];
      end
      default: begin
        s = b << g;
        sfpi_slice = {3'b000, s[7]};
      end
    endcase
  endfunction

  // shift one lane group into an accumulating byte
  function automatic logic [7:0] sfpi_merge(input logic [7:0] acc,
                                            input logic [1:0] mode,
                                            input logic [3:0] in);
    case (mode)
      LANES_DUAL: sfpi_merge = {acc[5:0], in[1:0]};
      LANES_QUAD: sfpi_merge = {acc[3:0], in[3:0]};
      default:    sfpi_merge = {acc[6:0], in[0]};
    endcase
  endfunction

  // index of the last group of a byte
  function automatic logic [2:0] sfpi_last_group(input logic [1:0] mode);
    case (mode)
      LANES_DUAL: sfpi_last_group = 3'h3;
      LANES_QUAD: sfpi_last_group = 3'h1;
      default:    sfpi_last_group = 3'h7;
    endcase
  endfunction

endpackage
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sfpi_pkg::*;
  logic sys_clk, reset, start, cpolHigh, writeDir, pauseReq, resetReq, pinRoleReset;
  logic quadLaneEnable, pinFunctionSelect, dedicatedResetPart, txEnable, fourLane;
  logic devRxValid, frameActive, pausedNow, inReset, spiMode3, busy, done;
  logic [1:0]                   laneMode;
  logic [7:0]                   hostTx, devTx, devRx, hostRx, devGot;
  logic [ADDR_WIDTH-1:0]        arrayAddr;
  logic [SECTOR_IDX_WIDTH-1:0]  sectorIdx;
  logic [BLOCK32_IDX_WIDTH-1:0] block32Idx;
  logic [BLOCK64_IDX_WIDTH-1:0] block64Idx;
  int                           fail_count = 0;
  int                           comparisons = 0;

  ////////////////////////////////////////////////////////////////////////////
  // the two ends joined by one link
  sfpi_link_if link ();
  sfpi_device_end u_sfpi_device_end (.sys_clk(sys_clk), .reset(reset), .link(link),
    .quadLaneEnable(quadLaneEnable), .pinFunctionSelect(pinFunctionSelect),
    .dedicatedResetPart(dedicatedResetPart), .fourLaneCommandMode(fourLane),
    .laneMode(laneMode), .txEnable(txEnable), .txByte(devTx), .rxByte(devRx),
    .rxValid(devRxValid), .frameActive(frameActive), .pausedNow(pausedNow),
    .inReset(inReset), .spiMode3(spiMode3), .arrayAddr(arrayAddr),
    .sectorIdx(sectorIdx), .block32Idx(block32Idx), .block64Idx(block64Idx));
  sfpi_host_end u_sfpi_host_end (.sys_clk(sys_clk), .reset(reset), .link(link),
    .start(start), .cpolHigh(cpolHigh), .laneMode(laneMode), .writeDir(writeDir),
    .txByte(hostTx), .pauseReq(pauseReq), .resetReq(resetReq),
    .pinRoleReset(pinRoleReset), .dedicatedResetPart(dedicatedResetPart),
    .busy(busy), .done(done), .rxByte(hostRx));
  sfpi_link_sva u_sfpi_link_sva (.sys_clk(sys_clk), .reset(reset), .sck(link.sck),
    .selectN(link.selectN), .hostResetNOut(link.hostResetNOut),
    .hostResetNOe(link.hostResetNOe), .hostLaneOut(link.hostLaneOut),
    .hostLaneOe(link.hostLaneOe), .devLaneOut(link.devLaneOut),
    .devLaneOe(link.devLaneOe), .lane(link.lane), .resetN(link.resetN));

  // clock and capture of each byte the device hands up
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (devRxValid === 1'b1) devGot <= devRx;

  ////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic tally_and_finish();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one byte across the link, optionally paused midway
  task automatic xfer(input logic cp, input logic [1:0] md, input logic wr,
                      input logic [7:0] hb, input logic [7:0] db, input logic ps);
    int n;
    cpolHigh = cp;
    laneMode = md;
    writeDir = wr;
    hostTx = hb;
    devTx = db;
    txEnable = (md == LANES_SINGLE) || !wr;
    repeat (4) @(negedge sys_clk);
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 600) begin
      @(negedge sys_clk);
      n++;
      if (ps && n == 20) pauseReq = 1'b1;
      if (n == 12) chk("pause flag", 9'h0, 9'(pausedNow));
      if (n == 12) chk("busy", 9'h1, 9'(busy));
      if (ps && n == 60) begin
        chk("pause flag", 9'h1, 9'(pausedNow));
        chk("frame kept", 9'h1, 9'(frameActive));
        pauseReq = 1'b0;
      end
    end
    chk("done seen", 9'h1, 9'(done));
    repeat (8) @(negedge sys_clk);
    chk("busy", 9'h0, 9'(busy));
    if (wr) chk("device rx", 9'(hb), 9'(devGot));
    if (!wr || md == LANES_SINGLE) chk("host rx", 9'(db), 9'(hostRx));
  endtask

  // every lane mode, both clock modes, both directions
  task automatic test_modes();
    logic [2:0] k;
    quadLaneEnable = 1'b1;
    for (int c = 0; c < 2; c++) begin
      for (int m = 0; m < 3; m++) begin
        for (int w = 0; w < 2; w++) begin
          k = 3'(c * 6 + m * 2 + w);
          xfer(c[0], m[1:0], w[0], {1'b0, k, 1'b0, ~k}, {1'b1, ~k, 1'b1, k}, 1'b0);
          chk("spi mode3", 9'(c), 9'(spiMode3));
        end
      end
    end
    // four-lane command mode without the quad enable bit
    fourLane = 1'b1;
    quadLaneEnable = 1'b0;
    xfer(1'b1, LANES_QUAD, 1'b1, 8'h5a, 8'hc3, 1'b0);
    xfer(1'b0, LANES_QUAD, 1'b0, 8'h0f, 8'h96, 1'b0);
    fourLane = 1'b0;
  endtask

  // pause on the shared pin, plain and on a part with its own reset pin
  task automatic test_pause(input logic ded);
    quadLaneEnable = 1'b0;
    dedicatedResetPart = ded;
    pinFunctionSelect = ded;
    pinRoleReset = 1'b0;
    xfer(1'b0, LANES_SINGLE, 1'b1, {3'h5, ded, 4'h6}, 8'ha7, 1'b1);
  endtask

  // hardware reset by dedicated pin or shared pin, shared pin as pause
  task automatic test_hwreset(input logic ded, input logic pfs, input logic exp);
    dedicatedResetPart = ded;
    pinFunctionSelect = pfs;
    pinRoleReset = !ded;
    resetReq = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk("in reset", 9'(exp), 9'(inReset));
    resetReq = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk("reset gone", 9'h0, 9'(inReset));
    pinRoleReset = 1'b0;
    xfer(1'b0, LANES_SINGLE, 1'b1, {4'h9, pfs, ded, 2'h1}, 8'h3c, 1'b0);
  endtask

  // sector and block numbers of boundary addresses
  task automatic test_decode();
    logic [20:0] tbl [5] = '{21'h000fff, 21'h00f000, 21'h010000, 21'h1ef000, 21'h1fffff};
    int s;
    for (int i = 0; i < 5; i++) begin
      arrayAddr = tbl[i];
      s = int'(tbl[i]) / 4096;
      repeat (2) @(negedge sys_clk);
      chk("sector", 9'(s), 9'(sectorIdx));
      chk("block32", 9'(s / 8), 9'(block32Idx));
      chk("block64", 9'(s / 16), 9'(block64Idx));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    reset = 1'b1;
    start = 1'b0;
    cpolHigh = 1'b0;
    writeDir = 1'b0;
    pauseReq = 1'b0;
    resetReq = 1'b0;
    pinRoleReset = 1'b0;
    quadLaneEnable = 1'b1;
    fourLane = 1'b0;
    pinFunctionSelect = 1'b0;
    dedicatedResetPart = 1'b0;
    txEnable = 1'b0;
    laneMode = LANES_SINGLE;
    hostTx = 8'h00;
    devTx = 8'h00;
    arrayAddr = '0;
    repeat (12) @(negedge sys_clk);
    reset = 1'b0;
    repeat (8) @(negedge sys_clk);
    test_modes();
    test_pause(1'b0);
    test_pause(1'b1);
    test_hwreset(1'b1, 1'b1, 1'b1);
    test_hwreset(1'b0, 1'b1, 1'b1);
    test_hwreset(1'b0, 1'b0, 1'b0);
    test_decode();
    tally_and_finish();
  end

  initial begin
    #400000;
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
